// ### dac_data_receiver_dll_control.sv
`timescale 1ns/100ps
`include "dac_rx_regs.svh"
// Summary of operation
// - pin function field [1:0]: none, parity, frame; 3 reserved; resets 0.
// - bit 5 reads 1 when pin is parity, parity check is enabled and a parity type is selected.
// - bit 4 reads 1 when pin is frame and pin framing is enabled.
// - control 0 bit 7 enables delay loop; resets off.
// - control 0 bit 6 enables duty-cycle correction; resets on.
// - control 0 [3:0] signed-magnitude phase offset in 11.25 degree steps.
// - writing 1 to control 1 bit 7 clears the latched loop warning.
// - control 1 bit 6 picks long lock delay when 1, short when 0.
// - control 1 [5:4] picks controller clock divide 4, 16, 64, 512; resets 2.
// - control 1 [3:0] sets nominal middle delay tap; resets 9.
// - control 2 bit 6 turns forwarded clock driver on; resets off.
// - control 2 [5:3] maximum delay line length; resets 4.
// - control 2 [2:0] minimum delay line length; resets 3.
// - control 3 [2:1] duty-correction bandwidth; resets 2; [7:3] read zero.
// - control registers 0x0A to 0x0D reset to 0x40, 0x29, 0x23, 0x04.
// - loop warning reads 1 once the loop nears either end of delay line.
// - framing enable input gates frame-mode usage of the pin.
module dac_data_receiver_dll_control (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       ser_cs_n,
  input  wire logic       ser_clk,
  input  wire logic       ser_din,
  output logic            ser_dout,
  output logic            ser_dout_oe,
  input  wire logic       parity_check_en,
  input  wire logic [1:0] parity_type,
  input  wire logic       pin_framing_en,
  input  wire logic       loop_locked,
  input  wire logic       loop_near_edge,
  input  wire logic       loop_at_start,
  input  wire logic       loop_at_end,
  input  wire logic       loop_correct_phase,
  input  wire logic       incoming_data_clock_on,
  input  wire logic       loop_lock_phase,
  input  wire logic       loop_running,
  output logic [1:0]      pin_role,
  output logic            parity_role_active,
  output logic            framing_role_active,
  output logic            loop_enable,
  output logic            duty_correction_enable,
  output logic [3:0]      phase_offset,
  output logic            warn_clear_pulse,
  output logic            lock_delay_long,
  output logic [1:0]      controller_clock_div,
  output logic [3:0]      delay_middle,
  output logic            forwarded_data_clock_en,
  output logic [2:0]      delay_max,
  output logic [2:0]      delay_min,
  output logic [1:0]      duty_bandwidth,
  output logic            loop_warning
);
  import dac_rx_pkg::*;

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic             clk_dly_reg;

  assign async_in = {ser_cs_n, ser_clk, ser_din, loop_locked, loop_near_edge,
                     loop_at_start, loop_at_end, loop_correct_phase,
                     incoming_data_clock_on, loop_lock_phase, loop_running};

  // two flops per asynchronous input
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          sync1_reg[gi] <= (gi == NSYNC - 1); // chip select idles high
          sync2_reg[gi] <= (gi == NSYNC - 1);
        end else begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // delayed serial clock for edge detection
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_dly_reg <= 1'b0;
    end else begin
      clk_dly_reg <= sync2_reg[9];
    end
  end

  logic cs_n_s;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;
  logic [7:0] loop_state_s;

  assign cs_n_s       = sync2_reg[10];
  assign sclk_rise    = sync2_reg[9] & ~clk_dly_reg;
  assign sclk_fall    = ~sync2_reg[9] & clk_dly_reg;
  assign din_s        = sync2_reg[8];
  assign loop_state_s = sync2_reg[7:0];

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // merge written bits under a mask, keep the rest
  function automatic logic [7:0] merge_bits(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] mask);
    merge_bits = (old_v & ~mask) | (new_v & mask);
  endfunction : merge_bits

  // ----------------------------------------------------------------------
  // serial port sequencer
  // ----------------------------------------------------------------------
  ser_state_t  state_reg, state_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [7:0]  sh_in_reg, sh_in_next;
  logic [7:0]  sh_out_reg, sh_out_next;
  logic        rd_reg, rd_next;
  logic [6:0]  addr_reg, addr_next;
  logic        dout_reg, dout_next;
  logic        dout_oe_reg, dout_oe_next;
  logic        wr_strobe;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;

  assign wr_data = {sh_in_reg[6:0], din_s};

  // next state of the serial frame: rw bit, 7 address bits, 8 data bits
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    sh_in_next   = sh_in_reg;
    sh_out_next  = sh_out_reg;
    rd_next      = rd_reg;
    addr_next    = addr_reg;
    dout_next    = dout_reg;
    dout_oe_next = dout_oe_reg;
    wr_strobe    = 1'b0;
    case (state_reg)
      SER_IDLE: begin
        cnt_next     = 4'h0;
        dout_oe_next = 1'b0;
        if (!cs_n_s) begin
          state_next = SER_HEAD;
        end
      end
      SER_HEAD: begin
        if (sclk_rise) begin
          sh_in_next = {sh_in_reg[6:0], din_s};
          cnt_next   = cnt_reg + 4'h1;
          if (cnt_reg == `SER_HEAD_LAST_BIT) begin
            rd_next     = sh_in_reg[6];
            addr_next   = {sh_in_reg[5:0], din_s};
            sh_out_next = 8'h00;
            state_next  = SER_DATA;
          end
        end
      end
      SER_DATA: begin
        if (cnt_reg == 4'h8 && rd_reg && sh_out_reg == 8'h00 &&
            !dout_oe_reg) begin
          sh_out_next = rd_data;
        end
        if (sclk_fall && rd_reg) begin
          dout_next    = sh_out_reg[7];
          dout_oe_next = 1'b1;
          sh_out_next  = {sh_out_reg[6:0], 1'b0};
        end
        if (sclk_rise) begin
          sh_in_next = {sh_in_reg[6:0], din_s};
          cnt_next   = cnt_reg + 4'h1;
          if (cnt_reg == `SER_FRAME_LAST_BIT) begin
            wr_strobe  = ~rd_reg;
            state_next = SER_END;
          end
        end
      end
      SER_END: begin
        if (sclk_fall) begin
          dout_oe_next = 1'b0;
        end
      end
      default: begin
        state_next = SER_IDLE;
      end
    endcase
    if (cs_n_s) begin
      state_next   = SER_IDLE;
      dout_oe_next = 1'b0;
    end
  end

  // serial port registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= SER_IDLE;
      cnt_reg     <= 4'h0;
      sh_in_reg   <= 8'h00;
      sh_out_reg  <= 8'h00;
      rd_reg      <= 1'b0;
      addr_reg    <= 7'h00;
      dout_reg    <= 1'b0;
      dout_oe_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      sh_in_reg   <= sh_in_next;
      sh_out_reg  <= sh_out_next;
      rd_reg      <= rd_next;
      addr_reg    <= addr_next;
      dout_reg    <= dout_next;
      dout_oe_reg <= dout_oe_next;
    end
  end

  assign ser_dout    = dout_reg;
  assign ser_dout_oe = dout_oe_reg;

  // ----------------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------------
  logic [7:0] pin_fn_reg,  pin_fn_next;
  logic [7:0] ctl0_reg,    ctl0_next;
  logic [7:0] ctl1_reg,    ctl1_next;
  logic [7:0] ctl2_reg,    ctl2_next;
  logic [7:0] ctl3_reg,    ctl3_next;
  logic       warn_reg,    warn_next;
  logic       clr_reg,     clr_next;
  logic       par_reg,     par_next;
  logic       frm_reg,     frm_next;

  // write decode and derived status
  always_comb begin
    pin_fn_next = pin_fn_reg;
    ctl0_next   = ctl0_reg;
    ctl1_next   = ctl1_reg;
    ctl2_next   = ctl2_reg;
    ctl3_next   = ctl3_reg;
    clr_next    = 1'b0;
    if (wr_strobe) begin
      case (addr_reg)
        `OFS_SYNC_PIN_FUNCTION: pin_fn_next = merge_bits(pin_fn_reg,
                          wr_data, `WMASK_SYNC_PIN_FUNCTION);
        `OFS_LOOP_CONTROL:    ctl0_next = merge_bits(ctl0_reg, wr_data,
                                   `WMASK_LOOP_CONTROL);
        `OFS_LOOP_TIMING: begin
          ctl1_next = merge_bits(ctl1_reg, wr_data,
                                 `WMASK_LOOP_TIMING);
          clr_next  = wr_data[`TIM_WARN_CLEAR_BIT];
        end
        `OFS_DELAY_LIMITS:    ctl2_next = merge_bits(ctl2_reg, wr_data,
                                   `WMASK_DELAY_LIMITS);
        `OFS_DUTY_CORRECTION: ctl3_next = merge_bits(ctl3_reg, wr_data,
                                   `WMASK_DUTY_CORRECTION);
        default: begin
        end
      endcase
    end
    // latch warning, set wins over clear
    warn_next = (warn_reg & ~clr_next) | loop_state_s[6];
    par_next  = (pin_fn_next[1:0] == `PIN_ROLE_PARITY) && parity_check_en &&
                (parity_type != `PARITY_TYPE_NONE);
    frm_next  = (pin_fn_next[1:0] == `PIN_ROLE_FRAME) &&
                pin_framing_en;
  end

  // register bank flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_fn_reg <= `RST_SYNC_PIN_FUNCTION;
      ctl0_reg   <= `RST_LOOP_CONTROL;
      ctl1_reg   <= `RST_LOOP_TIMING;
      ctl2_reg   <= `RST_DELAY_LIMITS;
      ctl3_reg   <= `RST_DUTY_CORRECTION;
      warn_reg   <= 1'b0;
      clr_reg    <= 1'b0;
      par_reg    <= 1'b0;
      frm_reg    <= 1'b0;
    end else begin
      pin_fn_reg <= pin_fn_next;
      ctl0_reg   <= ctl0_next;
      ctl1_reg   <= ctl1_next;
      ctl2_reg   <= ctl2_next;
      ctl3_reg   <= ctl3_next;
      warn_reg   <= warn_next;
      clr_reg    <= clr_next;
      par_reg    <= par_next;
      frm_reg    <= frm_next;
    end
  end

  // read multiplexer, unmapped addresses read zero
  always_comb begin
    case (addr_reg)
      `OFS_SYNC_PIN_FUNCTION: rd_data = {pin_fn_reg[7:6], par_reg, frm_reg,
                                         2'b00, pin_fn_reg[1:0]};
      `OFS_RESERVED_FIXED:  rd_data = `RST_RESERVED_FIXED;
      `OFS_LOOP_CONTROL:    rd_data = ctl0_reg;
      `OFS_LOOP_TIMING:     rd_data = ctl1_reg;
      `OFS_DELAY_LIMITS:    rd_data = ctl2_reg;
      `OFS_DUTY_CORRECTION: rd_data = {5'b00000, ctl3_reg[2:0]};
      `OFS_LOOP_STATE:      rd_data = {loop_state_s[7], warn_reg,
                                       loop_state_s[5:0]};
      default:              rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // control outputs, all straight from flops
  // ----------------------------------------------------------------------
  assign pin_role                = pin_fn_reg[1:0];
  assign parity_role_active      = par_reg;
  assign framing_role_active     = frm_reg;
  assign loop_enable             = ctl0_reg[`CTL_LOOP_ENABLE_BIT];
  assign duty_correction_enable  = ctl0_reg[`CTL_DUTY_ENABLE_BIT];
  assign phase_offset            = ctl0_reg[3:0];
  assign warn_clear_pulse        = clr_reg;
  assign lock_delay_long         = ctl1_reg[`TIM_LONG_DELAY_BIT];
  assign controller_clock_div    = ctl1_reg[5:4];
  assign delay_middle            = ctl1_reg[3:0];
  assign forwarded_data_clock_en = ctl2_reg[6];
  assign delay_max               = ctl2_reg[5:3];
  assign delay_min               = ctl2_reg[2:0];
  assign duty_bandwidth          = ctl3_reg[2:1];
  assign loop_warning            = warn_reg;

endmodule : dac_data_receiver_dll_control

// ### dac_rx_regs.svh
`ifndef DAC_RX_REGS_SVH
`define DAC_RX_REGS_SVH

// ----------------------------------------------------------------------
// register offsets (7-bit serial address)
// ----------------------------------------------------------------------
`define OFS_SYNC_PIN_FUNCTION   7'h07
`define OFS_RESERVED_FIXED      7'h08
`define OFS_LOOP_CONTROL        7'h0A
`define OFS_LOOP_TIMING         7'h0B
`define OFS_DELAY_LIMITS        7'h0C
`define OFS_DUTY_CORRECTION     7'h0D
`define OFS_LOOP_STATE          7'h0E

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_SYNC_PIN_FUNCTION   8'h00
`define RST_RESERVED_FIXED      8'h58
`define RST_LOOP_CONTROL        8'h40
`define RST_LOOP_TIMING         8'h29
`define RST_DELAY_LIMITS        8'h23
`define RST_DUTY_CORRECTION     8'h04

// ----------------------------------------------------------------------
// writable bit masks
// ----------------------------------------------------------------------
`define WMASK_SYNC_PIN_FUNCTION 8'hC3
`define WMASK_LOOP_CONTROL      8'hFF
`define WMASK_LOOP_TIMING       8'hFF
`define WMASK_DELAY_LIMITS      8'hFF
`define WMASK_DUTY_CORRECTION   8'h07

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PIN_PARITY_ACTIVE_BIT   5
`define PIN_FRAMING_ACTIVE_BIT  4
`define PIN_ROLE_NONE           2'h0
`define PIN_ROLE_PARITY         2'h1
`define PIN_ROLE_FRAME          2'h2
`define CTL_LOOP_ENABLE_BIT     7
`define CTL_DUTY_ENABLE_BIT     6
`define TIM_WARN_CLEAR_BIT      7
`define TIM_LONG_DELAY_BIT      6
`define PARITY_TYPE_NONE        2'h0

// ----------------------------------------------------------------------
// serial frame timing
// ----------------------------------------------------------------------
`define SER_HEAD_LAST_BIT       4'h7
`define SER_FRAME_LAST_BIT      4'hF

`endif

// ### dac_rx_pkg.sv
package dac_rx_pkg;

  // serial port sequencer, gray coded along idle-head-data-end
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_HEAD = 2'b01,
    SER_DATA = 2'b11,
    SER_END  = 2'b10
  } ser_state_t;

endpackage : dac_rx_pkg

// ### dac_rx_ctrl_sva.sv
`timescale 1ns/100ps
module dac_rx_ctrl_sva (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       ser_cs_n,
  input wire logic       ser_dout_oe,
  input wire logic       parity_check_en,
  input wire logic [1:0] parity_type,
  input wire logic       pin_framing_en,
  input wire logic       loop_near_edge,
  input wire logic [1:0] pin_role,
  input wire logic       parity_role_active,
  input wire logic       framing_role_active,
  input wire logic       loop_enable,
  input wire logic       duty_correction_enable,
  input wire logic [3:0] phase_offset,
  input wire logic       warn_clear_pulse,
  input wire logic       lock_delay_long,
  input wire logic [1:0] controller_clock_div,
  input wire logic [3:0] delay_middle,
  input wire logic       forwarded_data_clock_en,
  input wire logic [2:0] delay_max,
  input wire logic [2:0] delay_min,
  input wire logic [1:0] duty_bandwidth,
  input wire logic       loop_warning
);
  import dac_rx_pkg::*;
  // ------------------------------------------------------------------
  // control field relations
  // ------------------------------------------------------------------
  logic [23:0] ctl;

  // all control fields in one vector
  assign ctl = {loop_enable, duty_correction_enable, phase_offset,
                lock_delay_long, controller_clock_div, delay_middle,
                forwarded_data_clock_en, delay_max, delay_min,
                duty_bandwidth, pin_role};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence near_held;
    loop_near_edge [*3];
  endsequence
  sequence port_idle;
    ser_cs_n [*6];
  endsequence
  sequence port_released;
    ser_cs_n [*3];
  endsequence

  AST_PARITY_ROLE: assert property (1'b1 |=> parity_role_active ==
    (pin_role == 2'h1 && $past(parity_check_en) &&
     $past(parity_type) != 2'h0))
    else $error("parity usage flag wrong");
  AST_FRAME_ROLE: assert property (1'b1 |=> framing_role_active ==
    (pin_role == 2'h2 && $past(pin_framing_en)))
    else $error("framing usage flag wrong");
  AST_ROLE_NONE: assert property (pin_role == 2'h0 |->
    !parity_role_active && !framing_role_active)
    else $error("usage flag set with no pin role");
  AST_WARN_SET: assert property (near_held |=> ##[0:2] loop_warning)
    else $error("loop warning not latched");
  AST_WARN_CLEAR: assert property ($fell(loop_warning) |->
    warn_clear_pulse || $past(warn_clear_pulse) ||
    $past(warn_clear_pulse, 2))
    else $error("loop warning dropped without clear");
  AST_PULSE_ONE: assert property (warn_clear_pulse |=>
    !warn_clear_pulse)
    else $error("clear pulse longer than one cycle");
  AST_OE_RELEASE: assert property (port_released |=> !ser_dout_oe)
    else $error("data output driven with port deselected");
  AST_IDLE_HOLD: assert property (port_idle |-> $stable(ctl))
    else $error("control changed with port idle");
  AST_RESET_VALUES: assert property ($rose(rst_n) |-> ctl == 24'h414A38)
    else $error("control reset value wrong");
endmodule : dac_rx_ctrl_sva

// ### serial_host_model.sv
`timescale 1ns/100ps
module serial_host_model (
  input  wire logic clock,
  output logic      ser_cs_n,
  output logic      ser_clk,
  output logic      ser_din,
  input  wire logic ser_dout,
  input  wire logic ser_dout_oe
);
  // ------------------------------------------------------------------
  // serial port master, mode 0, six clocks high and seven clocks low per period
  // ------------------------------------------------------------------
  initial begin
    ser_cs_n = 1'b1;
    ser_clk  = 1'b0;
    ser_din  = 1'b0;
  end

  // one frame of nb bits; read bits are taken just before each rise
  // a released data output is seen inverted, so a late enable shows up
  task automatic xfer(input logic rw, input logic [6:0] a,
                      input logic [7:0] wd, input int nb,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {rw, a, (!rw && a == 7'h08) ? 8'h58 : wd};
    rd = 8'h00;
    @(posedge clock);
    ser_cs_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      @(posedge clock);
      ser_din <= sh[15 - i];
      repeat (6) @(posedge clock);
      if (i >= 8) rd = {rd[6:0], ser_dout_oe ? ser_dout : ~ser_dout};
      ser_clk <= 1'b1;
      repeat (6) @(posedge clock);
      ser_clk <= 1'b0;
    end
    repeat (8) @(posedge clock);
    ser_cs_n <= 1'b1;
    ser_din  <= ~ser_din; // idle line must not keep the last bit
    repeat (8) @(posedge clock);
  endtask : xfer
endmodule : serial_host_model

// ### dac_data_receiver_dll_control_tb_top.sv
`timescale 1ns/100ps
module dac_data_receiver_dll_control_tb_top;
  import dac_rx_pkg::*;
  // ------------------------------------------------------------------
  // signals, rows and checks
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } row_t;
  logic       clock, rst_n, ser_cs_n, ser_clk, ser_din, ser_dout;
  logic       ser_dout_oe, parity_check_en, pin_framing_en;
  logic       parity_role_active, framing_role_active, loop_enable;
  logic       duty_correction_enable, warn_clear_pulse, lock_delay_long;
  logic       forwarded_data_clock_en, loop_warning;
  logic [1:0] parity_type, pin_role, controller_clock_div, duty_bandwidth;
  logic [3:0] phase_offset, delay_middle;
  logic [2:0] delay_max, delay_min;
  logic [7:0] loop_in, rd, exp;
  logic [7:0] mirror [16];
  int         miscompares, n_checks, pulses;
  row_t rows [13] = '{
    '{7'h07, 8'hFF, 8'hC3}, '{7'h07, 8'h01, 8'h01},
    '{7'h0A, 8'h8B, 8'h8B}, '{7'h0A, 8'h40, 8'h40},
    '{7'h0B, 8'h7F, 8'h7F}, '{7'h0B, 8'h29, 8'h29},
    '{7'h0C, 8'hFF, 8'hFF}, '{7'h0C, 8'h23, 8'h23},
    '{7'h0D, 8'hFF, 8'h07}, '{7'h0D, 8'h04, 8'h04},
    '{7'h08, 8'h58, 8'h58}, '{7'h0E, 8'hFF, 8'hA5},
    '{7'h30, 8'h5A, 8'h00}};
  wire [23:0] act = {loop_enable, duty_correction_enable, phase_offset,
    lock_delay_long, controller_clock_div, delay_middle,
    forwarded_data_clock_en, delay_max, delay_min, duty_bandwidth, pin_role};
  wire [1:0]  usage = {parity_role_active, framing_role_active};

  dac_data_receiver_dll_control i_dac_data_receiver_dll_control (.*,
    .loop_locked(loop_in[7]), .loop_near_edge(loop_in[6]),
    .loop_at_start(loop_in[5]), .loop_at_end(loop_in[4]),
    .loop_correct_phase(loop_in[3]), .incoming_data_clock_on(loop_in[2]),
    .loop_lock_phase(loop_in[1]), .loop_running(loop_in[0]));
  serial_host_model i_serial_host_model (.*);

  // clock and clear-pulse counter
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) if (warn_clear_pulse === 1'b1) pulses++;

  function automatic logic [23:0] exp_vec();
    return {mirror[10][7:6], mirror[10][3:0], mirror[11][6:0],
            mirror[12][6:0], mirror[13][2:1], mirror[7][1:0]};
  endfunction : exp_vec
  task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t read exp %h got %h", $time, e, g);
    end
  endtask : chk_rd
  task automatic chk_vec(input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t port exp %h got %h", $time, e, g);
    end
  endtask : chk_vec
  task automatic rw_reg(input logic [6:0] a, input logic [7:0] d);
    i_serial_host_model.xfer(1'b0, a, d, 16, rd);
    i_serial_host_model.xfer(1'b1, a, 8'h00, 16, rd);
  endtask : rw_reg
  task automatic check_reset();
    mirror[7] = 8'h00;
    mirror[10] = 8'h40;
    mirror[11] = 8'h29;
    mirror[12] = 8'h23;
    mirror[13] = 8'h04;
    chk_vec(exp_vec(), act);
    foreach (mirror[a]) if (a == 7 || (a > 9 && a < 14)) begin
      i_serial_host_model.xfer(1'b1, 7'(a), 8'h00, 16, rd);
      chk_rd(mirror[a], rd);
    end
  endtask : check_reset
  task automatic summarize();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // main sequence: reset, table rows, then hand-written cases
  initial begin
    {rst_n, parity_check_en, pin_framing_en, parity_type, loop_in} <= '0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check_reset();
    loop_in <= 8'hA5;
    foreach (rows[r]) begin
      rw_reg(rows[r].addr, rows[r].wdata);
      chk_rd(rows[r].rdata, rd);
      if (rows[r].addr < 14) mirror[rows[r].addr[3:0]] = rows[r].rdata;
      chk_vec(exp_vec(), act);
    end
    for (int k = 0; k < 8; k++) begin
      parity_check_en <= (k != 4);
      parity_type     <= (k < 4) ? 2'(k) : 2'h3;
      pin_framing_en  <= (k > 5);
      exp = (k < 5) ? 8'h01 : (k < 7) ? 8'h02 : 8'h00;
      rw_reg(7'h07, exp);
      if (k > 0 && k < 4) exp = 8'h21;
      if (k == 6) exp = 8'h12;
      chk_rd(exp, rd);
      chk_vec(24'(exp[5:4]), 24'(usage));
    end
    mirror[7] = 8'h00;
    i_serial_host_model.xfer(1'b0, 7'h0A, 8'hFF, 12, rd);
    chk_vec(exp_vec(), act);
    loop_in <= 8'hE5;
    repeat (6) @(posedge clock);
    chk_vec(24'h1, {23'h0, loop_warning});
    rw_reg(7'h0B, 8'hA9);
    chk_vec(24'h1, {23'h0, loop_warning});
    loop_in <= 8'hA5;
    repeat (6) @(posedge clock);
    i_serial_host_model.xfer(1'b1, 7'h0E, 8'h00, 16, rd);
    chk_rd(8'hE5, rd);
    rw_reg(7'h0B, 8'hA9);
    chk_vec(24'h0, {23'h0, loop_warning});
    chk_vec(24'h2, 24'(pulses));
    i_serial_host_model.xfer(1'b1, 7'h0E, 8'h00, 16, rd);
    chk_rd(8'hA5, rd);
    rw_reg(7'h0A, 8'h8B);
    chk_rd(8'h8B, rd);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    check_reset();
    summarize();
  end
endmodule : dac_data_receiver_dll_control_tb_top

bind dac_data_receiver_dll_control dac_rx_ctrl_sva i_dac_rx_ctrl_sva (.*);
